/* File: rtl/uart_mp_map.vh */
// register map, field positions, reset values and state codes of the serial port
// assumes: included by bare name from every design file that needs a figure
`ifndef UART_MP_MAP_VH
`define UART_MP_MAP_VH
`define ADDR_DATA     3'h0
`define ADDR_CSA      3'h1
`define ADDR_CSB      3'h2
`define ADDR_SHARED   3'h3
`define ADDR_BAUD_LO  3'h4
`define CSA_RX_FULL   7
`define CSA_TX_DONE   6
`define CSA_TX_EMPTY  5
`define CSA_FRAME_ERR 4
`define CSA_OVERRUN   3
`define CSA_U2X       1
`define CSA_FILTER    0
`define CSB_RXCIE     7
`define CSB_TXCIE     6
`define CSB_UDRIE     5
`define CSB_RXEN      4
`define CSB_TXEN      3
`define CSB_SIZE2     2
`define CSB_RX9       1
`define CSB_TX9       0
`define REG_SEL       7
`define FC_TWO_STOP   3
`define FC_RESET      8'h86
`define SIZE_NINE     3'h7
`define CHAR_BASE     4'h5
`define CHAR_NINE     4'h9
`define SPB_NORM      5'h10
`define SPB_DBL       5'h08
`define ST_IDLE       2'h0
`define ST_START      2'h1
`define ST_DATA       2'h2
`define ST_STOP       2'h3
`endif

/* File: rtl/uart_mp_tx.v */
// serial transmit shifter: start bit, 5..9 data bits lsb first, one or two stop bits
// assumes: a baud sample tick from the parent, spb ticks per bit, load only when idle
`timescale 1ns/1ps
`include "uart_mp_map.vh"
module uart_mp_tx
(
    input  wire       clk,
    input  wire       rstn,
    input  wire       tick,
    input  wire [4:0] spb,
    input  wire [3:0] nbits,
    input  wire       two_stop,
    input  wire       load,
    input  wire [8:0] data,
    output reg        serial_out,
    output reg        busy,
    output reg        done
);
    reg [10:0] shift;
    reg [3:0]  left;
    reg [4:0]  tcnt;

    ////////////////////////////////////////////////////////////////////////
    // shifter bits from nbits up are forced to stop ones, so unused upper data is dropped
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            shift      <= 11'h7FF;
            left       <= 4'h0;
            tcnt       <= 5'h00;
            serial_out <= 1'b1;
            busy       <= 1'b0;
            done       <= 1'b0;
        end
        else
        begin
            done <= 1'b0;
            if (load && !busy)
            begin
                shift      <= {2'h0, data} | (11'h7FF << nbits);
                left       <= nbits + (two_stop ? 4'h2 : 4'h1);
                tcnt       <= 5'h00;
                serial_out <= 1'b0;                    // start bit
                busy       <= 1'b1;
            end
            else if (busy && tick)
            begin
                if (tcnt == spb - 5'h01)
                begin
                    tcnt <= 5'h00;
                    if (left == 4'h0)
                    begin
                        busy <= 1'b0;
                        done <= 1'b1;                  // last stop bit has fully left
                    end
                    else
                    begin
                        serial_out <= shift[0];
                        shift      <= {1'b1, shift[10:1]};
                        left       <= left - 4'h1;
                    end
                end
                else
                    tcnt <= tcnt + 5'h01;
            end
        end
    end
endmodule // uart_mp_tx

/* File: rtl/uart_mp_rx.v */
// serial receive sampler: start check at mid bit, data bits, first stop bit only
// assumes: serial_in is a raw pin, tick is the parent baud sample tick
`timescale 1ns/1ps
`include "uart_mp_map.vh"
module uart_mp_rx
(
    input  wire       clk,
    input  wire       rstn,
    input  wire       enable,
    input  wire       tick,
    input  wire [4:0] spb,
    input  wire [3:0] nbits,
    input  wire       serial_in,
    output reg        start_seen,
    output reg        done,
    output reg  [8:0] data,
    output reg        stop_bit
);
    reg [2:0] sync;
    reg       line;
    reg [1:0] state;
    reg [4:0] tcnt;
    reg [3:0] idx;

    ////////////////////////////////////////////////////////////////////////
    // three flops; the level moves only when the last two agree
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync <= 3'h7;
            line <= 1'b1;
        end
        else
        begin
            sync <= {sync[1:0], serial_in};
            if (sync[1] == sync[2])
                line <= sync[2];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bits are written by index, so upper bits of short characters stay zero
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state      <= `ST_IDLE;
            tcnt       <= 5'h00;
            idx        <= 4'h0;
            data       <= 9'h000;
            stop_bit   <= 1'b1;
            start_seen <= 1'b0;
            done       <= 1'b0;
        end
        else
        begin
            start_seen <= 1'b0;
            done       <= 1'b0;
            if (!enable)
                state <= `ST_IDLE;
            else
            case (state)
                `ST_IDLE:
                    if (!line)
                    begin
                        state <= `ST_START;
                        tcnt  <= 5'h00;
                    end
                `ST_START:
                    if (tick && tcnt == (spb >> 1))
                    begin
                        tcnt <= 5'h00;
                        idx  <= 4'h0;
                        data <= 9'h000;
                        // a high line at mid start is a spike
                        state      <= line ? `ST_IDLE : `ST_DATA;
                        start_seen <= !line;
                    end
                    else if (tick)
                        tcnt <= tcnt + 5'h01;
                `ST_DATA:
                    if (tick && tcnt == spb - 5'h01)
                    begin
                        tcnt      <= 5'h00;
                        data[idx] <= line;
                        idx       <= idx + 4'h1;
                        if (idx == nbits - 4'h1)
                            state <= `ST_STOP;
                    end
                    else if (tick)
                        tcnt <= tcnt + 5'h01;
                `ST_STOP:
                    if (tick && tcnt == spb - 5'h01)
                    begin
                        stop_bit <= line;
                        done     <= 1'b1;
                        state    <= `ST_IDLE;              // next start may follow at once
                    end
                    else if (tick)
                        tcnt <= tcnt + 5'h01;
                default:
                    state <= `ST_IDLE;
            endcase
        end
    end
endmodule // uart_mp_rx

/* File: rtl/uart_mp_core.v */
// serial port core: register port, transmit buffer, two entry receive fifo,
// address frame filter and the shared baud-high / frame-config location
// assumes: one 200 MHz clock, a register master that never waits, raw pins
//
// The register offsets and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "uart_mp_map.vh"
module uart_mp_core
#(
    parameter BAUD_W = 12
)
(
    input  wire       clk,
    input  wire       rstn,
    input  wire [2:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    input  wire       tx_complete_ack,
    output reg        rx_irq_req,
    output reg        tx_irq_req,
    output reg        tx_empty_irq_req,
    input  wire       serial_in,
    output wire       serial_out,
    output reg        serial_out_en
);
    ////////////////////////////////////////////////////////////////////////
    // software visible state
    reg [7:0]        ctrl_b;
    reg [7:0]        frame_config;
    reg [3:0]        baud_div_high;
    reg [7:0]        baud_div_low;
    reg              multiproc_filter_enable;
    reg              double_speed;
    reg              tx_complete;
    reg              shared_rd_last;

    // transmit buffer
    reg [8:0]        tx_buf;
    reg              tx_buf_full;

    // receive fifo and the character waiting behind it
    reg [10:0]       fifo [0:1];
    reg              head;
    reg [1:0]        count;
    reg [10:0]       wait_entry;
    reg              wait_valid;
    reg              overrun_pend;

    // baud generator
    reg [BAUD_W-1:0] baud_cnt;
    reg              tick;

    wire             tx_busy;
    wire             tx_done;
    wire             rx_start;
    wire             rx_done;
    wire [8:0]       rx_data;
    wire             rx_stop;

    ////////////////////////////////////////////////////////////////////////
    // decoded configuration
    wire [2:0] size_sel  = {ctrl_b[`CSB_SIZE2], frame_config[2:1]};
    wire       nine_bit  = (size_sel == `SIZE_NINE);
    wire [3:0] nbits     = nine_bit ? `CHAR_NINE : (`CHAR_BASE + {2'h0, size_sel[1:0]});
    wire [4:0] spb       = double_speed ? `SPB_DBL : `SPB_NORM;
    wire       rx_en     = ctrl_b[`CSB_RXEN];
    wire       tx_en     = ctrl_b[`CSB_TXEN];
    wire       tx_buf_empty = !tx_buf_full;

    // bus access strobes
    wire       wr_data   = wr && addr == `ADDR_DATA;
    wire       rd_data   = rd && addr == `ADDR_DATA;
    wire       wr_csa    = wr && addr == `ADDR_CSA;
    wire       wr_shared = wr && addr == `ADDR_SHARED;
    wire       rd_shared = rd && addr == `ADDR_SHARED;

    ////////////////////////////////////////////////////////////////////////
    // baud tick: one per (divider + 1) clocks, counts restart on every wrap
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            baud_cnt <= {BAUD_W{1'b0}};
            tick     <= 1'b0;
        end
        else if (baud_cnt == {BAUD_W{1'b0}})
        begin
            baud_cnt <= {baud_div_high, baud_div_low};
            tick     <= 1'b1;
        end
        else
        begin
            baud_cnt <= baud_cnt - {{(BAUD_W-1){1'b0}}, 1'b1};
            tick     <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // frame type and filter decision on each received character
    wire frame_type   = nine_bit ? rx_data[8] : rx_stop;
    wire is_address   = frame_type;
    // data frames vanish under filtering; address frames pass as usual
    wire frame_accept = rx_done && rx_en &&
                        (!multiproc_filter_enable || is_address);
    // entry layout: overrun, frame error, ninth bit, eight data bits
    wire [10:0] new_entry = {1'b0, !rx_stop, rx_data};

    ////////////////////////////////////////////////////////////////////////
    // fifo bookkeeping: pop first, then refill from the waiting slot, then new data
    wire       pop        = rd_data && count != 2'h0;
    wire [1:0] fill       = count - {1'b0, pop};
    wire       push_wait  = wait_valid && fill != 2'h2;
    wire       push_new   = frame_accept && fill != 2'h2 && !push_wait;
    wire       to_wait    = frame_accept && !push_new;
    wire       next_head  = head ^ pop;
    wire       widx       = next_head ^ fill[0];
    wire [1:0] next_count = fill + {1'b0, push_wait | push_new};
    wire [10:0] head_entry = fifo[head];

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            fifo[0]      <= 11'h000;
            fifo[1]      <= 11'h000;
            head         <= 1'b0;
            count        <= 2'h0;
            wait_entry   <= 11'h000;
            wait_valid   <= 1'b0;
            overrun_pend <= 1'b0;
        end
        else if (!rx_en)
        begin
            // flushing also drops the error flags carried by each entry
            head         <= 1'b0;
            count        <= 2'h0;
            wait_valid   <= 1'b0;
            overrun_pend <= 1'b0;
        end
        else
        begin
            head  <= next_head;
            count <= next_count;
            if (push_wait)
                fifo[widx] <= {overrun_pend, wait_entry[9:0]};
            else if (push_new)
                fifo[widx] <= new_entry;
            if (push_wait)
                overrun_pend <= 1'b0;
            // a fresh start bit with full fifo and a waiting char is an overrun
            if (rx_start && wait_valid && count == 2'h2)
                overrun_pend <= 1'b1;
            if (to_wait)
            begin
                wait_entry <= new_entry;
                wait_valid <= 1'b1;
            end
            else if (push_wait)
                wait_valid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit buffer: written only while empty, drained into an idle shifter
    wire tx_load = tx_en && tx_buf_full && !tx_busy;

    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            tx_buf      <= 9'h000;
            tx_buf_full <= 1'b0;
        end
        else if (wr_data && tx_buf_empty)
        begin
            tx_buf      <= {ctrl_b[`CSB_TX9], wdata};
            tx_buf_full <= 1'b1;
        end
        else if (tx_load)
            tx_buf_full <= 1'b0;
    end

    // pin stays owned while a frame is ongoing or pending; a pending frame is not sent while disabled
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            serial_out_en <= 1'b0;
        else
            serial_out_en <= tx_en || tx_busy || tx_buf_full;
    end

    ////////////////////////////////////////////////////////////////////////
    // tx complete: the setting event outranks a same cycle clear
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            tx_complete <= 1'b0;
        else if (tx_done && !tx_buf_full && !tx_load)
            tx_complete <= 1'b1;
        else if (tx_complete_ack || (wr_csa && wdata[`CSA_TX_DONE]))
            tx_complete <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // control writes; the shared location is steered by its top bit
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ctrl_b                  <= 8'h00;
            frame_config            <= `FC_RESET;
            baud_div_high           <= 4'h0;
            baud_div_low            <= 8'h00;
            multiproc_filter_enable <= 1'b0;
            double_speed            <= 1'b0;
        end
        else if (wr)
        begin
            case (addr)
                `ADDR_CSA:
                begin
                    multiproc_filter_enable <= wdata[`CSA_FILTER];
                    double_speed            <= wdata[`CSA_U2X];
                end
                `ADDR_CSB:
                    ctrl_b <= {wdata[7:2], 1'b0, wdata[`CSB_TX9]};
                `ADDR_SHARED:
                    if (wdata[`REG_SEL])
                        frame_config <= {1'b1, wdata[6:0]};
                    else
                        baud_div_high <= wdata[3:0];
                `ADDR_BAUD_LO:
                    baud_div_low <= wdata;
                default:
                    baud_div_low <= baud_div_low;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // timed double read: any cycle without a shared read forgets the first one
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            shared_rd_last <= 1'b0;
        else
            shared_rd_last <= rd_shared;
    end

    ////////////////////////////////////////////////////////////////////////
    // status assembly; frame error and overrun belong to the head character
    wire       rx_complete = count != 2'h0;
    wire       head_frame_err = rx_complete && head_entry[9];
    wire       head_overrun   = rx_complete && head_entry[10];
    wire [7:0] status_a    = {rx_complete, tx_complete, tx_buf_empty, head_frame_err,
                              head_overrun, 1'b0, double_speed, multiproc_filter_enable};
    wire [7:0] status_b    = {ctrl_b[7:2], rx_complete && head_entry[8],
                              ctrl_b[`CSB_TX9]};

    // read data stands in the cycle after the strobe only
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdata <= 8'h00;
        else if (rd)
        begin
            case (addr)
                `ADDR_DATA:
                    rdata <= rx_complete ? head_entry[7:0] : 8'h00;
                `ADDR_CSA:
                    rdata <= status_a;
                `ADDR_CSB:
                    rdata <= status_b;
                `ADDR_SHARED:
                    rdata <= shared_rd_last ? frame_config
                                            : {4'h0, baud_div_high};
                `ADDR_BAUD_LO:
                    rdata <= baud_div_low;
                default:
                    rdata <= 8'h00;
            endcase
        end
        else
            rdata <= 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////
    // request levels for an outside interrupt controller, gated by the enables
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_irq_req       <= 1'b0;
            tx_irq_req       <= 1'b0;
            tx_empty_irq_req <= 1'b0;
        end
        else
        begin
            rx_irq_req       <= ctrl_b[`CSB_RXCIE] && rx_complete;
            tx_irq_req       <= ctrl_b[`CSB_TXCIE] && tx_complete;
            tx_empty_irq_req <= ctrl_b[`CSB_UDRIE] && tx_buf_empty;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // shifter has no view of the filter bit at all
    uart_mp_tx u_tx
    (
        .clk        (clk),
        .rstn       (rstn),
        .tick       (tick),
        .spb        (spb),
        .nbits      (nbits),
        .two_stop   (frame_config[`FC_TWO_STOP]),
        .load       (tx_load),
        .data       (tx_buf),
        .serial_out (serial_out),
        .busy       (tx_busy),
        .done       (tx_done)
    );

    uart_mp_rx u_rx
    (
        .clk        (clk),
        .rstn       (rstn),
        .enable     (rx_en),
        .tick       (tick),
        .spb        (spb),
        .nbits      (nbits),
        .serial_in  (serial_in),
        .start_seen (rx_start),
        .done       (rx_done),
        .data       (rx_data),
        .stop_bit   (rx_stop)
    );
endmodule // uart_mp_core

/* File: sim/uart_mp_core_chk.sv */
// assertions on the serial port core pins, bound onto every core
// assumes: one clock, reset active low
`timescale 1ns/1ps
module uart_mp_core_chk
(
    input wire       clk,
    input wire       rstn,
    input wire [2:0] addr,
    input wire [7:0] wdata,
    input wire       wr,
    input wire       rd,
    input wire [7:0] rdata,
    input wire       rx_irq_req,
    input wire       tx_empty_irq_req,
    input wire       serial_out,
    input wire       serial_out_en
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // read data stands one cycle only
    property p_rd_idle; !$past(rd) |-> rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata without read");
    // a lone shared read gives baud high, whose bit 7 reads low
    property p_sh_one;
        rd && addr == 3'h3 && !($past(rd) && $past(addr) == 3'h3) |=> !rdata[7]; endproperty
    a_sh_one: assert property (p_sh_one) else $error("lone shared read");
    property p_sh_two; rd && addr == 3'h3 ##1 rd && addr == 3'h3 |=> rdata[7]; endproperty
    a_sh_two: assert property (p_sh_two) else $error("second shared read");
    // no low stretch is shorter than eight clocks, even at double speed
    property p_start; $fell(serial_out) |-> !serial_out [*8]; endproperty
    a_start: assert property (p_start) else $error("short low bit");
    property p_drive; $fell(serial_out) |-> serial_out_en; endproperty
    a_drive: assert property (p_drive) else $error("low pin not driven");
    property p_idle; !serial_out_en |-> serial_out; endproperty
    a_idle: assert property (p_idle) else $error("undriven pin not idle");
    // the flush waits a cycle for the new enable, the request one more
    property p_rx_off; wr && addr == 3'h2 && !wdata[4] |=> ##2 !rx_irq_req; endproperty
    a_rx_off: assert property (p_rx_off) else $error("rx flag kept");
    property p_tx_empty;
        wr && addr == 3'h0 && tx_empty_irq_req |=> ##1 !tx_empty_irq_req; endproperty
    a_tx_empty: assert property (p_tx_empty) else $error("buffer empty while full");
endmodule // uart_mp_core_chk
bind uart_mp_core uart_mp_core_chk u_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rx_irq_req(rx_irq_req),
    .tx_empty_irq_req(tx_empty_irq_req), .serial_out(serial_out),
    .serial_out_en(serial_out_en));

/* File: sim/uart_mp_peer.sv */
// far-side port: sends frames to the core, samples what it sends
// assumes: divider zero at normal speed, so 16 clocks a bit
`timescale 1ns/1ps
module uart_mp_peer
(
    input wire clk,
    input wire tx_line,
    output reg line
);
    localparam int BIT = 16;
    // line idles high between frames
    initial line = 1'b1;
    task automatic send(input logic [8:0] d, input int n, input logic stop);
        line <= 1'b0;
        repeat (BIT) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            line <= d[i];
            repeat (BIT) @(posedge clk);
        end
        line <= stop;
        repeat (BIT) @(posedge clk);
        line <= 1'b1;
        repeat (2 * BIT) @(posedge clk);
    endtask
    // sample each bit near its centre after a start
    task automatic grab(output logic [8:0] d, input int n);
        d = 9'h000;
        wait (tx_line === 1'b0);
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < n; i++)
        begin
            repeat (BIT) @(posedge clk);
            d[i] = tx_line;
        end
    endtask
endmodule // uart_mp_peer

/* File: sim/uart_multiproc_and_register_access_test.sv */
// bench for the serial port core
// assumes: peer model on the pins, divider left at zero
`timescale 1ns/1ps
module uart_multiproc_and_register_access_test;
    logic       clk = 0;
    logic       rstn = 0;
    logic       wr = 0;
    logic       rd = 0;
    logic       ack = 0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic [8:0] got;
    wire  [7:0] rdata;
    wire        rx_irq, tx_irq, empty_irq, ser_in, ser_out, ser_en;
    int         num_errors = 0;
    int         total_checks = 0;
    uart_mp_core u_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .tx_complete_ack(ack), .rx_irq_req(rx_irq), .tx_irq_req(tx_irq),
        .tx_empty_irq_req(empty_irq), .serial_in(ser_in), .serial_out(ser_out),
        .serial_out_en(ser_en));
    uart_mp_peer u_peer (.clk(clk), .tx_line(ser_out), .line(ser_in));
    // 200 MHz clock
    initial
        forever #2.5 clk = ~clk;
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data is only there in the cycle after the strobe
    task automatic rreg(input logic [2:0] a, input logic [7:0] e, input bit two = 0);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        if (two)
        begin
            #1 chk("shared", 8'h00, rdata);
            @(posedge clk);
        end
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    task automatic txchk(input logic [7:0] e);
        u_peer.grab(got, 8);
        chk("serial_out", e, got[7:0]);
    endtask
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // a full run needs about 2300 clocks
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        test_done();
    end
    initial
    begin
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        rreg(3'h1, 8'h20);
        rreg(3'h3, 8'h86, 1);
        rreg(3'h3, 8'h00);
        wreg(3'h3, 8'h8E);
        rreg(3'h3, 8'h8E, 1);
        wreg(3'h1, 8'h01);
        wreg(3'h2, 8'hB8);
        wreg(3'h0, 8'hA5);
        wreg(3'h0, 8'h3C);
        wreg(3'h0, 8'h77);
        txchk(8'hA5);
        txchk(8'h3C);
        repeat (100) @(posedge clk);
        rreg(3'h1, 8'h61);
        wreg(3'h1, 8'h41);
        u_peer.send(9'h0C3, 8, 1'b0);
        u_peer.send(9'h05A, 8, 1'b1);
        rreg(3'h1, 8'hA1);
        rreg(3'h0, 8'h5A);
        wreg(3'h1, 8'h00);
        u_peer.send(9'h033, 8, 1'b0);
        u_peer.send(9'h011, 8, 1'b1);
        u_peer.send(9'h044, 8, 1'b1);
        u_peer.send(9'h055, 8, 1'b1);
        rreg(3'h1, 8'hB0);
        rreg(3'h0, 8'h33);
        rreg(3'h1, 8'hA0);
        rreg(3'h0, 8'h11);
        rreg(3'h1, 8'hA8);
        wreg(3'h2, 8'hA8);
        rreg(3'h1, 8'h20);
        wreg(3'h3, 8'h80);
        wreg(3'h2, 8'hB8);
        u_peer.send(9'h1FF, 5, 1'b1);
        rreg(3'h0, 8'h1F);
        wreg(3'h0, 8'h03);
        txchk(8'hE3);
        wreg(3'h2, 8'hF8);
        rreg(3'h1, 8'h60);
        chk("tx_irq", 8'h01, {7'h00, tx_irq});
        @(posedge clk);
        ack <= 1'b1;
        @(posedge clk);
        ack <= 1'b0;
        rreg(3'h1, 8'h20);
        chk("tx_irq", 8'h00, {7'h00, tx_irq});
        wreg(3'h3, 8'h86);
        wreg(3'h2, 8'hBC);
        wreg(3'h1, 8'h41);
        u_peer.send(9'h0F0, 9, 1'b1);
        u_peer.send(9'h177, 9, 1'b1);
        rreg(3'h2, 8'hBE);
        rreg(3'h0, 8'h77);
        test_done();
    end
endmodule // uart_multiproc_and_register_access_test
